// ===== hdl/dacc_pkg.sv
package dacc_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int          SAMPLE_W      = 12;
  localparam int          RESULT_DEPTH  = 16;
  localparam int          STAGE_DEPTH   = 4;
  localparam int          TAG_W         = 1;
  localparam int          WORD_W        = SAMPLE_W + TAG_W;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ       = 250;
  localparam int          MAX_KSPS      = 8000;
  localparam int          SAMPLE_CYC    = (CLK_MHZ * 1000) / MAX_KSPS;
  localparam int          PULSE_NS      = 8;
  localparam int          PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------
  localparam logic [1:0]  REG_CTRL0     = 2'h0;
  localparam logic [1:0]  REG_CTRL1     = 2'h1;
  localparam int          C0_CONT       = 0;
  localparam int          C0_EN_A       = 1;
  localparam int          C0_EN_B       = 2;
  localparam int          C0_DIFF       = 3;
  localparam int          C0_SCAN       = 4;
  localparam int          C1_AV_HIGH    = 0;
  localparam int          C1_AV_PULSE   = 1;
  localparam int          C1_SEP_STRB   = 2;
  localparam int          C1_BUF_RST    = 3;
  localparam int          C1_LVL_LSB    = 4;
  localparam logic [9:0]  CTRL0_RST     = 10'h006;
  localparam logic [9:0]  CTRL1_RST     = 10'h011;

  // ----------------------------------------------------------------
  // Conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DACC_IDLE  = 2'b00,
    DACC_CONV  = 2'b01,
    DACC_PUSH  = 2'b10
  } dacc_state_t;

endpackage

// ===== hdl/dacc_top.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Staging FIFO
// ----------------------------------------------------------------
module dacc_fifo #(
  parameter int W = 13,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
  logic         push, pop;
  always_comb begin
    in_ready  = (wp_q - rp_q) != (AW+1)'(D);
    out_valid = wp_q != rp_q;
    out_data  = mem_q[rp_q[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_d      = flush ? '0 : wp_q + (AW+1)'(push);
    rp_d      = flush ? '0 : rp_q + (AW+1)'(pop);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ----------------------------------------------------------------
// Conversion control
// ----------------------------------------------------------------
// Functional notes
// [R1] Twelve-bit results at up to one sample per SAMPLE_CYC clocks.
// [R2] Software selects modes by writing control registers.
// [R3] Two modes: single conversion and continuous conversion.
// [R4] Single mode conversions are timed by the internal oscillator.
// [R5] Host supplies free-running conversion clock in continuous mode.
// [R6] Internal oscillator is disabled in continuous mode.
// [R7] Falling start strobe holds all enabled channels and starts one conversion.
// [R8] Two single-ended or one differential input sampled together.
// [R9] Each input enabled individually; single-ended or differential selectable.
// [R10] Auto-scan converts both inputs in turn without host action.
// [R11] Results buffered in a sixteen-word result buffer.
// [R12] Low-active select asserted only when driven low.
// [R13] High-active select asserted only when driven high.
// [R14] Sample ready flag reflects result buffer fill level.
// [R15] Sample ready flag polarity is configurable.
// [R16] Sample ready flag is a static level or a pulse.
// [R17] Overrun flag sets on overflow, clears on reset or buffer reset.
// [R18] Host drives register address on the two top data lines.
// [R19] Combined read/write strobe or separate write and read strobes.
// [R20] Host's first access must be an initialising write.
// [R21] Results stored in conversion order, read oldest first.
// [R22] Bus responds only while both selects are asserted.
module dacc_top #(
  parameter int SW = dacc_pkg::SAMPLE_W,
  parameter int RD = dacc_pkg::RESULT_DEPTH
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          conversion_clock_input,
  input  wire logic          select_low_active,
  input  wire logic          select_high_active,
  input  wire logic          write_strobe_n,
  input  wire logic          read_strobe_n,
  input  wire logic [SW-1:0] data_in,
  output logic      [SW-1:0] data_out,
  output logic      [SW-1:0] data_oe,
  input  wire logic [SW-1:0] sample_a,
  input  wire logic [SW-1:0] sample_b,
  output logic               hold_inputs,
  output logic               osc_enable,
  output logic               sample_ready_flag,
  output logic               buffer_overrun_flag
);
  localparam int AW = $clog2(RD);
  localparam int WW = dacc_pkg::WORD_W;
  // ----------------------------------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------------------------------
  logic       rs1_q, rs2_q;
  logic [4:0] s1_q, s2_q, s3_q;
  logic       rst_ok_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_ok_n = rs2_q;
  always_ff @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      s1_q <= 5'h1B;
      s2_q <= 5'h1B;
      s3_q <= 5'h1B;
    end else begin
      s1_q <= {conversion_clock_input, select_low_active, select_high_active, write_strobe_n, read_strobe_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic cck, cck_prev, sel, wr_n, rd_n, wr_prev_n, rd_prev_n;
  // [R12] [R13] [R22] Select qualification.
  assign sel       = !s2_q[3] && s2_q[2];
  assign cck       = s2_q[4];
  assign cck_prev  = s3_q[4];
  assign wr_n      = s2_q[1];
  assign rd_n      = s2_q[0];
  assign wr_prev_n = s3_q[1];
  assign rd_prev_n = s3_q[0];

  // ----------------------------------------------------------------
  // Control registers and bus access
  // ----------------------------------------------------------------
  logic [9:0]    c0_q, c0_d, c1_q, c1_d;
  logic [SW-1:0] din1_q, din_q;
  logic          wr_ev, rd_ev, rd_act, buf_rst;
  always_ff @(posedge ref_clk) begin
    din1_q <= data_in;
    din_q  <= din1_q;
  end

  always_comb begin
    // [R19] Strobe style.
    if (c1_q[dacc_pkg::C1_SEP_STRB]) begin
      wr_ev  = sel && !wr_n && wr_prev_n;
      rd_ev  = sel && !rd_n && rd_prev_n;
      rd_act = sel && !rd_n;
    end else begin
      wr_ev  = sel && !rd_n && rd_prev_n && !wr_n;
      rd_ev  = sel && !rd_n && rd_prev_n && wr_n;
      rd_act = sel && !rd_n && wr_n;
    end
    c0_d    = c0_q;
    c1_d    = c1_q;
    c1_d[dacc_pkg::C1_BUF_RST] = 1'b0;
    // [R2] [R18] Register write by address lines.
    if (wr_ev && din_q[SW-1:SW-2] == dacc_pkg::REG_CTRL0) begin
      c0_d = din_q[9:0];
    end else if (wr_ev && din_q[SW-1:SW-2] == dacc_pkg::REG_CTRL1) begin
      c1_d = din_q[9:0];
    end
    buf_rst = c1_q[dacc_pkg::C1_BUF_RST];
  end

  always_ff @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      c0_q <= dacc_pkg::CTRL0_RST;
      c1_q <= dacc_pkg::CTRL1_RST;
    end else begin
      c0_q <= c0_d;
      c1_q <= c1_d;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  dacc_pkg::dacc_state_t st_q, st_d;
  logic [7:0]    cnt_q, cnt_d;
  logic          ch_q, ch_d, second_q, second_d, hold_d;
  logic [WW-1:0] stg_data;
  logic          stg_valid, stg_ready, start_ev, cont;
  assign cont = c0_q[dacc_pkg::C0_CONT];
  always_comb begin
    // [R3] [R5] [R7] Start on falling strobe or rising conversion clock edge.
    start_ev = cont ? (cck && !cck_prev) : (!cck && cck_prev);
    st_d     = st_q;
    cnt_d    = cnt_q;
    ch_d     = ch_q;
    second_d = second_q;
    hold_d   = 1'b0;
    stg_valid = 1'b0;
    // [R8] [R9] Channel tag and data per enabled input.
    stg_data = {ch_q, ch_q ? sample_b : sample_a};
    case (st_q)
      dacc_pkg::DACC_IDLE: begin
        if (start_ev && (c0_q[dacc_pkg::C0_EN_A] || c0_q[dacc_pkg::C0_EN_B])) begin
          st_d     = dacc_pkg::DACC_CONV;
          cnt_d    = 8'((dacc_pkg::SAMPLE_CYC) - 1);
          ch_d     = !c0_q[dacc_pkg::C0_SCAN] && c0_q[dacc_pkg::C0_EN_B] && !c0_q[dacc_pkg::C0_EN_A];
          second_d = c0_q[dacc_pkg::C0_SCAN] ||
                     (c0_q[dacc_pkg::C0_EN_A] && c0_q[dacc_pkg::C0_EN_B] && !c0_q[dacc_pkg::C0_DIFF]);
          hold_d   = 1'b1;
        end
      end
      dacc_pkg::DACC_CONV: begin
        // [R1] [R4] Conversion timed by internal oscillator count.
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          st_d = dacc_pkg::DACC_PUSH;
        end
      end
      dacc_pkg::DACC_PUSH: begin
        stg_valid = 1'b1;
        if (stg_ready) begin
          // [R10] Auto-scan second input.
          if (second_q) begin
            second_d = 1'b0;
            ch_d     = 1'b1;
            cnt_d    = 8'((dacc_pkg::SAMPLE_CYC) - 1);
            st_d     = dacc_pkg::DACC_CONV;
          end else begin
            st_d = dacc_pkg::DACC_IDLE;
          end
        end
      end
      default: st_d = dacc_pkg::DACC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      st_q        <= dacc_pkg::DACC_IDLE;
      cnt_q       <= 8'h00;
      ch_q        <= 1'b0;
      second_q    <= 1'b0;
      hold_inputs <= 1'b0;
      osc_enable  <= 1'b1;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      ch_q        <= ch_d;
      second_q    <= second_d;
      hold_inputs <= hold_d;
      // [R6] Oscillator off in continuous mode.
      osc_enable  <= !c0_d[dacc_pkg::C0_CONT];
    end
  end

  // ----------------------------------------------------------------
  // Staging FIFO and result buffer
  // ----------------------------------------------------------------
  logic [WW-1:0] f_data;
  logic          f_valid, f_pop;

  dacc_fifo #(.W(WW), .D(dacc_pkg::STAGE_DEPTH)) u_stage (
    .clk       (ref_clk),
    .rst_n     (rst_ok_n),
    .flush     (buf_rst),
    .in_data   (stg_data),
    .in_valid  (stg_valid),
    .in_ready  (stg_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  logic [SW-1:0] buf_q [RD];
  logic [AW:0]   wp_q, wp_d, rp_q, rp_d, lvl;
  logic          ov_d, full, rd_pop;
  always_comb begin
    lvl    = wp_q - rp_q;
    full   = lvl == (AW+1)'(RD);
    rd_pop = rd_ev && lvl != '0;
    // [R17] Overflow drops the new word and sets the sticky flag.
    f_pop  = f_valid;
    // [R21] Write in order, read oldest first.
    wp_d   = buf_rst ? '0 : wp_q + (AW+1)'(f_valid && !full);
    rp_d   = buf_rst ? '0 : rp_q + (AW+1)'(rd_pop);
    ov_d   = (buffer_overrun_flag && !buf_rst) || (f_valid && full);
  end
  // [R11] Sixteen-word result storage.
  always_ff @(posedge ref_clk) begin
    if (f_valid && !full) begin
      buf_q[wp_q[AW-1:0]] <= f_data[SW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Output flags and data
  // ----------------------------------------------------------------
  logic [7:0] pc_q, pc_d;
  logic       lvl_hit, lvl_prev_q, av_d, lvl_ge;
  always_comb begin
    // [R14] Fill-level trigger.
    lvl_ge  = lvl >= (AW+1)'(c1_q[dacc_pkg::C1_LVL_LSB +: 4]) && lvl != '0;
    lvl_hit = lvl_ge && !lvl_prev_q;
    pc_d    = lvl_hit ? 8'(dacc_pkg::PULSE_CYC) : (pc_q != 8'h00 ? pc_q - 8'h01 : 8'h00);
    // [R16] Static level or pulse.
    av_d    = c1_q[dacc_pkg::C1_AV_PULSE] ? (pc_d != 8'h00) : lvl_ge;
    // [R15] Polarity.
    if (!c1_q[dacc_pkg::C1_AV_HIGH]) begin
      av_d = !av_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      wp_q                <= '0;
      rp_q                <= '0;
      buffer_overrun_flag <= 1'b0;
      pc_q                <= 8'h00;
      lvl_prev_q          <= 1'b0;
      sample_ready_flag   <= 1'b0;
      data_out            <= '0;
      data_oe             <= '0;
    end else begin
      wp_q                <= wp_d;
      rp_q                <= rp_d;
      buffer_overrun_flag <= ov_d;
      pc_q                <= pc_d;
      lvl_prev_q          <= lvl_ge;
      sample_ready_flag   <= av_d;
      if (rd_ev) begin
        data_out <= lvl != '0 ? buf_q[rp_q[AW-1:0]] : '0;
      end
      data_oe  <= {SW{rd_act}};
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ovf_sticky;
    @(posedge ref_clk) disable iff (!rst_ok_n) buffer_overrun_flag && !buf_rst |=> buffer_overrun_flag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overrun flag dropped"); // [R17]
  property p_osc_off;
    @(posedge ref_clk) disable iff (!rst_ok_n) cont |-> !osc_enable;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator on in continuous mode"); // [R6]
  property p_no_drive_unsel;
    @(posedge ref_clk) disable iff (!rst_ok_n) !sel |=> data_oe == '0;
  endproperty
  a_no_drive_unsel: assert property (p_no_drive_unsel) else $error("bus driven while unselected"); // [R22]
  property p_level_bound;
    @(posedge ref_clk) disable iff (!rst_ok_n) lvl <= (AW+1)'(RD);
  endproperty
  a_level_bound: assert property (p_level_bound) else $error("buffer level beyond depth"); // [R11]
  property p_start_conv;
    @(posedge ref_clk) disable iff (!rst_ok_n)
    st_q == dacc_pkg::DACC_IDLE && start_ev && c0_q[dacc_pkg::C0_EN_A] |=> st_q == dacc_pkg::DACC_CONV && hold_inputs;
  endproperty
  a_start_conv: assert property (p_start_conv) else $error("start edge missed"); // [R7]
  property p_hold_pulse;
    @(posedge ref_clk) disable iff (!rst_ok_n) hold_inputs |=> !hold_inputs;
  endproperty
  a_hold_pulse: assert property (p_hold_pulse) else $error("input hold longer than one cycle"); // [R7]

  c_overflow: cover property (@(posedge ref_clk) disable iff (!rst_ok_n) $rose(buffer_overrun_flag));
  c_scan:     cover property (@(posedge ref_clk) disable iff (!rst_ok_n) second_q ##1 !second_q);
  c_read:     cover property (@(posedge ref_clk) disable iff (!rst_ok_n) rd_pop);
endmodule

`default_nettype wire

// ===== verification/dacc_host.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Host processor model on the parallel side
// ----------------------------------------------------------------
module dacc_host (
  input  wire logic                          ref_clk,
  input  wire logic                          sep,
  input  wire logic [dacc_pkg::SAMPLE_W-1:0] data_out,
  input  wire logic [dacc_pkg::SAMPLE_W-1:0] data_oe,
  output logic                               select_low_active,
  output logic                               select_high_active,
  output logic                               write_strobe_n,
  output logic                               read_strobe_n,
  output logic      [dacc_pkg::SAMPLE_W-1:0] data_in,
  output logic                               conversion_clock_input,
  output logic                               rd_done,
  output logic      [dacc_pkg::SAMPLE_W-1:0] rd_data,
  output logic      [dacc_pkg::SAMPLE_W-1:0] rd_oe
);
  initial begin
    select_low_active      = 1'b1;
    select_high_active     = 1'b0;
    write_strobe_n         = 1'b1;
    read_strobe_n          = 1'b1;
    data_in                = 12'h000;
    conversion_clock_input = 1'b1;
    rd_done                = 1'b0;
    rd_data                = 12'h000;
    rd_oe                  = 12'h000;
  end

  // One bus cycle; sel is {low-active select, high-active select}.
  // Address on top lines.
  task automatic access(input logic [1:0] sel, input logic wr, input logic [11:0] d);
    @(negedge ref_clk);
    select_low_active  = sel[1];
    select_high_active = sel[0];
    data_in            = d;
    @(negedge ref_clk);
    write_strobe_n = !wr;
    read_strobe_n  = wr & sep;
    repeat (4) @(negedge ref_clk);
    rd_data = data_out;
    rd_oe   = data_oe;
    rd_done = !wr;
    @(negedge ref_clk);
    write_strobe_n     = 1'b1;
    read_strobe_n      = 1'b1;
    select_low_active  = 1'b1;
    select_high_active = 1'b0;
    data_in            = ~d;
    rd_done            = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  // Start strobe or a burst of conversion clock periods; idles high.
  // Conversion clock supply.
  task automatic strobe_conv(input int n, input int half);
    repeat (n) begin
      conversion_clock_input = 1'b0;
      repeat (half) @(negedge ref_clk);
      conversion_clock_input = 1'b1;
      repeat (half) @(negedge ref_clk);
    end
  endtask
endmodule

`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; $display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end

module tb_top;
  localparam int         SW  = dacc_pkg::SAMPLE_W;
  localparam logic [1:0] SEL = 2'b01;
  logic          ref_clk = 1'b0;
  logic          rst_n;
  logic          sep;
  logic [SW-1:0] sa;
  logic [SW-1:0] sb;
  wire  logic    cci, sla, sha, wsn, rsn, hold_inputs, osc_enable, sample_ready_flag, buffer_overrun_flag, rd_done;
  wire  logic [SW-1:0] data_in, data_out, data_oe, rd_data, rd_oe;
  logic [2*SW-1:0] exp_q[$];
  logic [2*SW-1:0] nxt;
  int            bad_count = 0;
  int            samples_checked = 0;

  always #2 ref_clk = ~ref_clk;

  dacc_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .conversion_clock_input(cci), .select_low_active(sla),
    .select_high_active(sha), .write_strobe_n(wsn), .read_strobe_n(rsn), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .sample_a(sa), .sample_b(sb), .hold_inputs(hold_inputs), .osc_enable(osc_enable),
    .sample_ready_flag(sample_ready_flag), .buffer_overrun_flag(buffer_overrun_flag));

  dacc_host u_host (.ref_clk(ref_clk), .sep(sep), .data_out(data_out), .data_oe(data_oe), .select_low_active(sla),
    .select_high_active(sha), .write_strobe_n(wsn), .read_strobe_n(rsn), .data_in(data_in),
    .conversion_clock_input(cci), .rd_done(rd_done), .rd_data(rd_data), .rd_oe(rd_oe));

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rd_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("unexpected at %0t ns: read with nothing noted", $time);
      end else begin
        nxt = exp_q.pop_front();
        `CHK({rd_oe, rd_data}, nxt)
      end
    end
  end

  task automatic wr(input logic [1:0] a, input logic [9:0] v);
    u_host.access(SEL, 1'b1, {a, v});
  endtask

  task automatic rd(input int n);
    repeat (n) u_host.access(SEL, 1'b0, 12'h000);
  endtask

  task automatic conv(input logic both, input logic note);
    @(negedge ref_clk);
    sa = SW'($urandom());
    sb = SW'($urandom());
    u_host.strobe_conv(1, 4);
    if (note) exp_q.push_back({12'hFFF, sa});
    if (note && both) exp_q.push_back({12'hFFF, sb});
    repeat (80) @(negedge ref_clk);
  endtask

  task automatic give_verdict();
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("unexpected at %0t ns: results left unread", $time);
    end
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    $display("unexpected at %0t ns: run did not finish", $time);
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [9:0] modes [3];
    logic       both  [3];
    modes = '{10'h006, 10'h00A, 10'h016};
    both  = '{1'b1, 1'b0, 1'b1};
    rst_n = 1'b0;
    sep   = 1'b0;
    sa    = 12'h000;
    sb    = 12'h000;
    void'($urandom(63));
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    `CHK(sample_ready_flag, 1'b0)
    `CHK(buffer_overrun_flag, 1'b0)
    `CHK(osc_enable, 1'b1)
    wr(dacc_pkg::REG_CTRL1, 10'h010);
    `CHK(sample_ready_flag, 1'b1)
    wr(dacc_pkg::REG_CTRL0, 10'h002);
    repeat (3) conv(1'b0, 1'b1);
    `CHK(sample_ready_flag, 1'b0)
    rd(3);
    for (int i = 0; i < 3; i++) begin
      wr(dacc_pkg::REG_CTRL0, modes[i]);
      conv(both[i], 1'b1);
      rd(both[i] ? 2 : 1);
    end
    u_host.access(2'b11, 1'b1, {dacc_pkg::REG_CTRL0, 10'h003});
    u_host.access(2'b00, 1'b1, {dacc_pkg::REG_CTRL0, 10'h003});
    `CHK(osc_enable, 1'b1)
    wr(dacc_pkg::REG_CTRL0, 10'h003);
    `CHK(osc_enable, 1'b0)
    u_host.strobe_conv(3, 20);
    repeat (3) exp_q.push_back({12'hFFF, sa});
    repeat (40) @(negedge ref_clk);
    rd(3);
    wr(dacc_pkg::REG_CTRL0, 10'h002);
    `CHK(osc_enable, 1'b1)
    wr(dacc_pkg::REG_CTRL1, 10'h015);
    sep = 1'b1;
    `CHK(sample_ready_flag, 1'b0)
    conv(1'b0, 1'b1);
    `CHK(sample_ready_flag, 1'b1)
    rd(1);
    `CHK(sample_ready_flag, 1'b0)
    wr(dacc_pkg::REG_CTRL1, 10'h017);
    conv(1'b0, 1'b1);
    `CHK(sample_ready_flag, 1'b0)
    rd(1);
    repeat (24) conv(1'b0, 1'b0);
    `CHK(buffer_overrun_flag, 1'b1)
    wr(dacc_pkg::REG_CTRL1, 10'h01D);
    `CHK(buffer_overrun_flag, 1'b0)
    exp_q.push_back({12'hFFF, 12'h000});
    rd(1);
    exp_q.push_back({12'h000, 12'h000});
    u_host.access(2'b00, 1'b0, 12'h000);
    repeat (4) @(negedge ref_clk);
    give_verdict();
  end
endmodule

`default_nettype wire
